// >>> src/event_status_map.svh
// Register offsets, field positions, reset values and counts.
// Assumes byte-wide register addresses on the serial register port.
`ifndef EVENT_STATUS_MAP_SVH
`define EVENT_STATUS_MAP_SVH
`define ADDR_CTRL 8'h00
`define ADDR_EV1 8'h05
`define ADDR_EV2 8'h06
`define ADDR_RPT 8'h22
`define ADDR_MISS 8'h22
`define ADDR_ERR 8'h25
`define ADDR_FC_HI 8'h43
`define ADDR_FC_MID 8'h44
`define ADDR_FC_LO 8'h45
`define CTRL_NARROW_BIT 1
`define CTRL_CHAN_BIT 2
`define E1_RX_AVAIL 0
`define E1_TX_AVAIL 1
`define E1_ARB_FAIL 2
`define E1_TX_DONE 3
`define E1_BUSY_CHG 4
`define E1_TIMER_ZERO 5
`define E1_SUPV_CHG 6
`define E2_WORD_CHG 0
`define E2_DOTTING 1
`define E2_FV_SYNC 2
`define E2_FC_SYNC 3
`define E2_IDLE_CHG 4
`define E2_ERR_UPD 5
`define E2_PIO 6
`define E2_TERM 7
`define RST_BYTE 8'h00
`define RST_MISS 8'h03
`define RST_COUNT 20'h00000
`define SYNC_RUN_NEED 2'h2
`endif

// >>> src/event_status_pkg.sv
// Types shared by the event and status logic.
// Assumes all sources run on the one system clock.
`default_nettype none
package event_status_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  typedef struct packed {
    logic rx_data_ready;
    logic tx_first_repeat;
    logic tx_burst_done;
    logic timer_zero;
    logic sat_out_of_band;
    logic colour_valid;
    logic rx_word_valid;
    logic dotting;
    logic sync_hit;
    logic sync_miss;
    logic idle_mode_change;
    logic err_rate_update;
    logic pio_sensed;
    logic afc_terminal;
  } event_in_s;
  typedef enum logic {phase_idle, phase_held} read_phase_e;
endpackage : event_status_pkg
`default_nettype wire

// >>> src/baseband_event_status_unit.sv
// Event flags, interrupt and status read-out of the baseband data processor.
// Assumes a serial interface front end that issues one-cycle read/write strobes
// on the system clock, and event sources that pulse for one cycle.
`include "event_status_map.svh"
`default_nettype none
module baseband_event_status_unit
  import event_status_pkg::*;
#(
  parameter int WORD_BITS = 28
) (
  input wire logic clock,
  input wire logic resetn,
  input wire reg_req_s req,
  input wire event_in_s ev_in,
  input wire logic forward_control_channel_busy,
  input wire logic busy_window,
  input wire logic fvc_msg_active,
  input wire logic [7:0] colour_code,
  input wire logic [WORD_BITS-1:0] rx_word,
  input wire logic [7:0] repeats_used,
  input wire logic [7:0] err_count,
  input wire logic [19:0] afc_count,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic irq,
  output logic sync,
  output logic counters_reset,
  output logic narrowband_mode,
  output logic channel_type_select
);

  function automatic logic hit(input reg_req_s r, input logic [7:0] a, input logic w);
    hit = (w ? r.wr : r.rd) && (r.addr == a);
  endfunction : hit

  logic [7:0] ctrl;
  logic [7:0] rx_avail_ie;
  logic [7:0] word_chg_ie;
  logic [7:0] missed_sync_limit;
  logic [7:0] event_reg_one;
  logic [7:0] event_reg_two;
  logic [7:0] ev2_buffer;
  read_phase_e phase;
  logic [7:0] rx_repeat_count;
  logic [7:0] narrowband_error_rate;
  logic [19:0] term_count;
  logic busy_q;
  logic have_word;
  logic [WORD_BITS-1:0] last_word;
  logic have_colour;
  logic [7:0] last_colour;
  logic fvc_synced;
  logic forward_control_channel_synced;
  logic [1:0] sync_run;
  logic [7:0] miss_cnt;

  wire rd_ev1 = hit(req, `ADDR_EV1, 1'b0);
  wire rd_ev2 = hit(req, `ADDR_EV2, 1'b0);
  wire rd_lo = hit(req, `ADDR_FC_LO, 1'b0);
  // Register write decode
  wire wr_ctrl = hit(req, `ADDR_CTRL, 1'b1);
  wire wr_ie1 = hit(req, `ADDR_EV1, 1'b1);
  wire wr_ie2 = hit(req, `ADDR_EV2, 1'b1);
  wire wr_miss = hit(req, `ADDR_MISS, 1'b1);
  wire wide = ~ctrl[`CTRL_NARROW_BIT];
  wire fvc_mode = ctrl[`CTRL_CHAN_BIT];
  wire busy_rise = forward_control_channel_busy & ~busy_q;
  wire busy_fall = ~forward_control_channel_busy & busy_q;
  wire word_new = ev_in.rx_word_valid & ~fvc_mode;
  wire word_differs = word_new & (~have_word | (rx_word != last_word));
  wire colour_new = ev_in.colour_valid & ~wide;
  wire colour_differs = colour_new & (~have_colour | (colour_code != last_colour));
  wire fvc_first_sync = ev_in.sync_hit & fvc_mode & fvc_msg_active & ~fvc_synced;
  wire forward_control_channel_hit = ev_in.sync_hit & ~fvc_mode;
  wire forward_control_channel_miss = ev_in.sync_miss & ~fvc_mode;
  wire [1:0] run_plus = sync_run + 2'h1;
  wire [7:0] miss_plus = miss_cnt + 8'h01;
  wire gain_sync = forward_control_channel_hit & ~forward_control_channel_synced & (run_plus == `SYNC_RUN_NEED);
  wire limit_on = missed_sync_limit != 8'h00;
  wire lose_sync = forward_control_channel_miss & forward_control_channel_synced & limit_on & (miss_plus == missed_sync_limit);
  wire fvc_sync_level = (fvc_synced & fvc_msg_active) | fvc_first_sync;
  wire forward_control_channel_sync_level = (forward_control_channel_synced | gain_sync) & ~lose_sync;

  logic [7:0] ev1_set;
  logic [7:0] ev2_set;
  always_comb begin
    ev1_set = 8'h00;
    ev1_set[`E1_RX_AVAIL] = ev_in.rx_data_ready;
    ev1_set[`E1_TX_AVAIL] = ev_in.tx_first_repeat;
    ev1_set[`E1_ARB_FAIL] = busy_rise & ~busy_window;
    ev1_set[`E1_TX_DONE] = ev_in.tx_burst_done;
    ev1_set[`E1_BUSY_CHG] = busy_rise | busy_fall;
    ev1_set[`E1_TIMER_ZERO] = ev_in.timer_zero;
    ev1_set[`E1_SUPV_CHG] = (ev_in.sat_out_of_band & wide) | colour_differs;
    ev2_set = 8'h00;
    ev2_set[`E2_WORD_CHG] = word_differs;
    ev2_set[`E2_DOTTING] = ev_in.dotting & fvc_mode & wide;
    ev2_set[`E2_FV_SYNC] = fvc_first_sync;
    ev2_set[`E2_FC_SYNC] = gain_sync | lose_sync;
    ev2_set[`E2_IDLE_CHG] = ev_in.idle_mode_change;
    ev2_set[`E2_ERR_UPD] = ev_in.err_rate_update;
    ev2_set[`E2_PIO] = ev_in.pio_sensed;
    ev2_set[`E2_TERM] = ev_in.afc_terminal;
  end

  // Read clears; a same-cycle event stays set
  wire [7:0] next_ev1 = (rd_ev1 ? 8'h00 : event_reg_one) | ev1_set;
  wire [7:0] next_ev2 = (rd_ev1 ? 8'h00 : event_reg_two) | ev2_set;
  wire next_held = rd_ev1 | ((phase == phase_held) & ~rd_ev2);
  wire pending = |(next_ev1 & rx_avail_ie) | |(next_ev2 & word_chg_ie);

  logic [7:0] read_mux;
  always_comb begin
    unique case (req.addr)
      `ADDR_EV1: read_mux = event_reg_one;
      `ADDR_EV2: read_mux = ev2_buffer;
      `ADDR_RPT: read_mux = rx_repeat_count;
      `ADDR_ERR: read_mux = narrowband_error_rate;
      `ADDR_FC_HI: read_mux = term_count[19:12];
      `ADDR_FC_MID: read_mux = term_count[11:4];
      `ADDR_FC_LO: read_mux = {term_count[3:0], 4'h0};
      default: read_mux = 8'h00;
    endcase
  end

  // Read port
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_data <= `RST_BYTE;
    end else if (req.rd) begin
      rd_data <= read_mux;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= req.rd;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      counters_reset <= 1'b0;
    end else begin
      counters_reset <= rd_lo;
    end
  end

  // Control writes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `RST_BYTE;
    end else if (wr_ctrl) begin
      ctrl <= req.wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_avail_ie <= `RST_BYTE;
    end else if (wr_ie1) begin
      rx_avail_ie <= req.wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      word_chg_ie <= `RST_BYTE;
    end else if (wr_ie2) begin
      word_chg_ie <= req.wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      missed_sync_limit <= `RST_MISS;
    end else if (wr_miss) begin
      missed_sync_limit <= req.wdata;
    end
  end

  // Event flags and interrupt
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      event_reg_one <= `RST_BYTE;
      event_reg_two <= `RST_BYTE;
    end else begin
      event_reg_one <= next_ev1;
      event_reg_two <= next_ev2;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ev2_buffer <= `RST_BYTE;
    end else if (rd_ev1) begin
      ev2_buffer <= event_reg_two;
    end else if (rd_ev2) begin
      ev2_buffer <= `RST_BYTE;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase <= phase_idle;
    end else begin
      phase <= next_held ? phase_held : phase_idle;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= pending & ~next_held;
    end
  end

  // Status capture
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_repeat_count <= `RST_BYTE;
    end else if (ev_in.rx_data_ready) begin
      rx_repeat_count <= repeats_used;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      narrowband_error_rate <= `RST_BYTE;
    end else if (ev_in.err_rate_update) begin
      narrowband_error_rate <= err_count;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      term_count <= `RST_COUNT;
    end else if (ev_in.afc_terminal) begin
      term_count <= afc_count;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= forward_control_channel_busy;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      have_word <= 1'b0;
      last_word <= '0;
    end else if (word_new) begin
      have_word <= 1'b1;
      last_word <= rx_word;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      have_colour <= 1'b0;
      last_colour <= `RST_BYTE;
    end else if (colour_new) begin
      have_colour <= 1'b1;
      last_colour <= colour_code;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fvc_synced <= 1'b0;
    end else if (!fvc_msg_active || !fvc_mode) begin
      fvc_synced <= 1'b0;
    end else if (fvc_first_sync) begin
      fvc_synced <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      forward_control_channel_synced <= 1'b0;
      sync_run <= 2'h0;
      miss_cnt <= `RST_BYTE;
    end else if (forward_control_channel_hit) begin
      miss_cnt <= `RST_BYTE;
      sync_run <= forward_control_channel_synced ? sync_run : run_plus;
      forward_control_channel_synced <= forward_control_channel_synced | gain_sync;
    end else if (forward_control_channel_miss) begin
      sync_run <= 2'h0;
      miss_cnt <= lose_sync ? `RST_BYTE : miss_plus;
      forward_control_channel_synced <= forward_control_channel_synced & ~lose_sync;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync <= 1'b0;
    end else begin
      sync <= fvc_mode ? fvc_sync_level : forward_control_channel_sync_level;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      narrowband_mode <= 1'b0;
    end else begin
      narrowband_mode <= ~wide;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      channel_type_select <= 1'b0;
    end else begin
      channel_type_select <= fvc_mode;
    end
  end

endmodule : baseband_event_status_unit
`default_nettype wire

// >>> verif/mcu_model.sv
// Microcontroller model: one-cycle register read and write strobes.
// Assumes the unit takes a strobe at the next rising edge.
`default_nettype none
module mcu_model
  import event_status_pkg::*;
(
  input wire logic clock,
  input wire logic [7:0] rd_data,
  output var reg_req_s req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clock);
    #1 req = '{!w, w, a, d};
    @(posedge clock);
    #1 req = '0;
    q = rd_data;
  endtask : access
endmodule : mcu_model
`default_nettype wire

// >>> verif/baseband_event_status_unit_asserts.sv
// Port checker for the event and status unit.
// Assumes one clock and an async active-low reset.
`default_nettype none
module baseband_event_status_unit_asserts
  import event_status_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire reg_req_s req,
  input wire event_in_s ev_in,
  input wire logic forward_control_channel_busy,
  input wire logic fvc_msg_active,
  input wire logic rd_valid,
  input wire logic irq,
  input wire logic sync,
  input wire logic counters_reset,
  input wire logic channel_type_select
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence rd_at(a);
    req.rd && req.addr == a;
  endsequence
  chk_read_answer: assert property (req.rd |=> rd_valid) else $error("read late");
  chk_low_clear: assert property (rd_at(8'h45) |=> counters_reset) else $error("no clear");
  chk_clear_cause: assert property (counters_reset |->
    $past(req.rd) && $past(req.addr) == 8'h45) else $error("stray clear");
  chk_irq_masked: assert property (rd_at(8'h05) |=> !irq) else $error("irq unmasked");
  chk_irq_cause: assert property ($rose(irq) |-> $past(ev_in) != 0 || $past(ev_in, 2) != 0
    || $past(req.rd) || $past(req.wr) || $past(req.wr, 2) || $past(forward_control_channel_busy) != $past(forward_control_channel_busy, 3))
    else $error("irq without cause");
  chk_sync_rise: assert property ($rose(sync) |-> $past(ev_in.sync_hit))
    else $error("sync without hit");
  chk_sync_drop: assert property (channel_type_select && $fell(fvc_msg_active) |=> !sync)
    else $error("sync held");
  chk_mode_copy: assert property (req.wr && req.addr == 8'h00 |-> ##2
    channel_type_select == $past(req.wdata[2], 2)) else $error("mode not copied");
endmodule : baseband_event_status_unit_asserts
bind baseband_event_status_unit baseband_event_status_unit_asserts asserts_inst (.clock(clock),
  .resetn(resetn), .req(req), .ev_in(ev_in), .forward_control_channel_busy(forward_control_channel_busy),
  .fvc_msg_active(fvc_msg_active), .rd_valid(rd_valid), .irq(irq), .sync(sync),
  .counters_reset(counters_reset), .channel_type_select(channel_type_select));
`default_nettype wire

// >>> verif/tb_baseband_event_status_unit.sv
// Self-checking bench with an integer model of the event registers.
// Assumes the package, the unit and the microcontroller model are compiled first.
`default_nettype none
module tb_baseband_event_status_unit
  import event_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, resetn, forward_control_channel_busy, busy_window, fvc_msg_active, irq, sync, narrowband_mode;
  logic [7:0] repeats_used, rp, rd_data, q, colour_code;
  logic [27:0] rx_word;
  logic [19:0] afc_count, af;
  reg_req_s req;
  event_in_s ev_in;
  int fail_count, check_count, cycles, seed, ev, i;
  int src[8] = '{13, 12, 11, 10, 9, 1, 3, 0};
  int dst[8] = '{0, 1, 3, 5, 6, 14, 12, 15};
  logic [7:0] rd_list[8] = '{8'h05, 8'h06, 8'h22, 8'h25, 8'h43, 8'h44, 8'h45, 8'h99};
  baseband_event_status_unit baseband_event_status_unit_inst (.clock(clock), .resetn(resetn),
    .req(req), .ev_in(ev_in), .forward_control_channel_busy(forward_control_channel_busy), .busy_window(busy_window),
    .fvc_msg_active(fvc_msg_active), .colour_code(colour_code), .rx_word(rx_word),
    .repeats_used(repeats_used), .err_count(rp), .afc_count(afc_count),
    .rd_data(rd_data), .rd_valid(), .irq(irq), .sync(sync), .counters_reset(),
    .narrowband_mode(narrowband_mode), .channel_type_select());
  mcu_model mcu_model_inst (.clock(clock), .rd_data(rd_data), .req(req));
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic check(input logic [7:0] got, input int exp);
    check_count++;
    if (got !== exp[7:0]) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp[7:0]);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input int exp);
    mcu_model_inst.access(0, a, 0, q);
    check(q, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, d);
    mcu_model_inst.access(1, a, d, q);
  endtask : wr
  task automatic pulse(input int s, input int d);
    @(posedge clock);
    #1 ev_in = event_in_s'(14'(1) << s);
    @(posedge clock);
    #1 ev_in = '0;
    ev |= d;
    @(posedge clock);
    #1;
  endtask : pulse
  task automatic drain;
    rd(8'h05, ev);
    rd(8'h06, ev >> 8);
    ev = 0;
    check({7'h0, irq}, 0);
  endtask : drain
  task automatic busy_to(input logic v, w, input int d);
    busy_window = w;
    forward_control_channel_busy = v;
    repeat (3) @(posedge clock);
    #1 ev |= d;
    drain();
  endtask : busy_to
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    seed = 32'h9334a2cd;
    resetn = 0;
    forward_control_channel_busy = 0;
    busy_window = 1;
    fvc_msg_active = 0;
    ev_in = '0;
    rx_word = 28'($random(seed));
    colour_code = 8'($random(seed));
    rp = 8'($random(seed));
    repeats_used = rp;
    afc_count = 20'($random(seed));
    af = afc_count;
    repeat (4) @(posedge clock);
    #1 resetn = 1;
    wr(8'h43, 8'h5a);
    for (i = 0; i < 8; i++) begin
      rd(rd_list[i], 0);
    end
    $display("test reset done");
    wr(8'h05, 8'hff);
    wr(8'h06, 8'hff);
    for (i = 0; i < 8; i++) begin
      pulse(src[i], 1 << dst[i]);
      check({7'h0, irq}, 1);
      drain();
    end
    afc_count = ~af;
    repeats_used = ~rp;
    rd(8'h43, af[19:12]);
    rd(8'h44, af[11:4]);
    rd(8'h45, {af[3:0], 4'h0});
    rd(8'h22, rp);
    $display("test flags and counts done");
    busy_to(1, 0, 8'h14);
    busy_to(0, 0, 8'h10);
    busy_to(1, 1, 8'h10);
    $display("test busy done");
    wr(8'h05, 8'hfe);
    wr(8'h06, 8'h01);
    pulse(13, 1);
    check({7'h0, irq}, 0);
    drain();
    for (i = 0; i < 3; i++) begin
      rx_word[0] = rx_word[0] ^ (i == 2);
      pulse(7, int'(i != 1) * 256);
      check({7'h0, irq}, i != 1);
      drain();
    end
    $display("test idle words done");
    wr(8'h22, 8'h02);
    for (i = 0; i < 4; i++) begin
      pulse(i < 2 ? 5 : 4, int'(i == 1 || i == 3) * 2048);
      check({7'h0, sync}, i == 1 || i == 2);
    end
    drain();
    wr(8'h00, 8'h04);
    fvc_msg_active = 1;
    pulse(5, 1024);
    check({7'h0, sync}, 1);
    pulse(6, 512);
    drain();
    fvc_msg_active = 0;
    repeat (2) @(posedge clock);
    #1 check({7'h0, sync}, 0);
    $display("test sync done");
    wr(8'h00, 8'h02);
    pulse(8, 64);
    drain();
    pulse(8, 0);
    pulse(9, 0);
    drain();
    colour_code = ~colour_code;
    pulse(8, 64);
    pulse(2, 8192);
    check({7'h0, narrowband_mode}, 1);
    drain();
    rd(8'h25, rp);
    $display("test narrowband done");
    close_out();
  end
endmodule : tb_baseband_event_status_unit
`default_nettype wire
